/* design/fsem_consts.svh */
// Constants of the fieldbus state error monitor: error codes, timing.
// Assumes inclusion by bare name from the package and the modules.
`ifndef FSEM_CONSTS_SVH
`define FSEM_CONSTS_SVH

// Main error groups
`define FSEM_MAIN_DL 8'h80
`define FSEM_MAIN_SM 8'h81

// Sub codes of main group 80
`define FSEM_SUB_FW_PROG 8'h05
`define FSEM_SUB_DESC 8'h06

// Sub codes of main group 81
`define FSEM_SUB_ILLEGAL 8'h01
`define FSEM_SUB_UNKNOWN 8'h02
`define FSEM_SUB_BOOT_REQ 8'h03
`define FSEM_SUB_FW_HW 8'h04
`define FSEM_SUB_MBX_BOOT 8'h05
`define FSEM_SUB_MBX_SM 8'h06
`define FSEM_SUB_SM_CFG 8'h07
`define FSEM_SUB_TX_STALE 8'h08

// Neutral values
`define FSEM_CODE_NONE 8'h00
`define FSEM_COUNT_ZERO 8'h00
`define FSEM_COUNT_ONE 8'h01
`define FSEM_COUNT_MAX 8'hFF

// Timing: clock rate and stale transmit data timeout
`define FSEM_CLK_HZ 40_000_000
`define FSEM_MS_PER_S 1000
`define FSEM_STALE_MS 1000
`define FSEM_CNT_ZERO 32'h0000_0000
`define FSEM_CNT_ONE 32'h0000_0001

`endif

/* design/fsem_pkg.sv */
// Types of the fieldbus state error monitor.
// Assumes the constants header is on the include path.
`include "fsem_consts.svh"

package fsem_pkg;

  // Network state machine states; codes 3'b101..3'b111 are undefined
  typedef enum logic [2:0] {
    FSEM_ST_INIT = 3'b000,
    FSEM_ST_PREOP = 3'b001,
    FSEM_ST_BOOT = 3'b010,
    FSEM_ST_SAFEOP = 3'b011,
    FSEM_ST_OP = 3'b100
  } fsem_state_e;

  typedef logic [7:0] fsem_code_t;

endpackage : fsem_pkg

/* design/fsem_stale_timer.sv */
// Watches refreshes of transmit process data and pulses once on timeout.
// Assumes refresh is a one-cycle pulse on the same clock.
`include "fsem_consts.svh"

module fsem_stale_timer
  import fsem_pkg::*;
#(
  parameter int unsigned LIMIT = `FSEM_CLK_HZ / `FSEM_MS_PER_S * `FSEM_STALE_MS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic refresh,
  output logic stale_pulse
);

  typedef struct packed {
    logic [31:0] cnt;
    logic fired;
    logic pulse;
  } fsem_timer_s;

  fsem_timer_s st_reg;
  fsem_timer_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.pulse = 1'b0;
    if (refresh) begin
      st_next.cnt = `FSEM_CNT_ZERO;
      st_next.fired = 1'b0;
    end else if (st_reg.cnt > 32'(LIMIT)) begin
      // Strictly longer than the timeout; report once per stall
      if (!st_reg.fired) begin
        st_next.pulse = 1'b1; // [RULE10]
        st_next.fired = 1'b1;
      end
    end else begin
      st_next.cnt = st_reg.cnt + `FSEM_CNT_ONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign stale_pulse = st_reg.pulse;

endmodule : fsem_stale_timer

/* design/fsem_err_latch.sv */
// Holds the main and sub code of the latest fault until cleared.
// Assumes set and clear are single-cycle strobes on the same clock.
`include "fsem_consts.svh"

module fsem_err_latch
  import fsem_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic set,
  input wire fsem_code_t set_main,
  input wire fsem_code_t set_sub,
  input wire logic clear,
  output fsem_code_t code_main,
  output fsem_code_t code_sub,
  output logic active
);

  typedef struct packed {
    fsem_code_t main_code;
    fsem_code_t sub_code;
    logic active;
  } fsem_latch_s;

  fsem_latch_s lt_reg;
  fsem_latch_s lt_next;

  always_comb begin
    lt_next = lt_reg;
    // A new fault wins over a clear in the same cycle
    if (set) begin
      lt_next.main_code = set_main; // [RULE12]
      lt_next.sub_code = set_sub; // [RULE12]
      lt_next.active = 1'b1;
    end else if (clear) begin
      lt_next.main_code = `FSEM_CODE_NONE;
      lt_next.sub_code = `FSEM_CODE_NONE;
      lt_next.active = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lt_reg <= '0;
    end else if (ce) begin
      lt_reg <= lt_next;
    end
  end

  assign code_main = lt_reg.main_code;
  assign code_sub = lt_reg.sub_code;
  assign active = lt_reg.active;

endmodule : fsem_err_latch

/* design/fsem_monitor.sv */
// Fieldbus state error monitor: detects faults of the slave network
// state machine, latches their codes and orders a fallback state.
// Assumes all inputs come from logic on mclk; the state machine itself
// lives outside and applies fallback_state when fault_pulse is high.
//
// Function
// [RULE1] Firmware download programming failure in bootstrap: code 80/5, stay in bootstrap.
// [RULE2] Description file mismatching firmware in init: code 80/6, stay in init.
// [RULE3] Illegal transition request: code 81/1, operational drops to safe-operational.
// [RULE4] Request for undefined state: code 81/2, operational drops to safe-operational.
// [RULE5] Unsupported bootstrap request from init: code 81/3, return to init.
// [RULE6] Firmware mismatching hardware in bootstrap or init: code 81/4, stay.
// [RULE7] Mailbox setup without bootstrap support on init-to-bootstrap: 81/5, go init.
// [RULE8] Bad mailbox sync unit setup in pre-operational: code 81/6, go to init.
// [RULE9] Bad sync unit setup in pre-operational or above: 81/7, settle pre-operational.
// [RULE10] Transmit data not refreshed over one second: 81/8, operational to safe-op.
// [RULE11] Master issues only defined, legal, ordered requests with consistent configuration.
// [RULE12] Latest fault main and sub code stay latched until cleared.
`include "fsem_consts.svh"

module fsem_monitor
  import fsem_pkg::*;
#(
  parameter int unsigned STALE_CYCLES = `FSEM_CLK_HZ / `FSEM_MS_PER_S * `FSEM_STALE_MS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire fsem_state_e net_state,
  input wire logic req_valid,
  input wire logic [2:0] req_state,
  input wire logic boot_supported,
  input wire logic mbx_boot_ok,
  input wire logic fw_program_fail,
  input wire logic desc_mismatch,
  input wire logic fw_hw_mismatch,
  input wire logic mbx_sm_invalid,
  input wire logic sm_cfg_invalid,
  input wire logic tx_refresh,
  input wire logic err_clear,
  output logic fault_pulse,
  output fsem_state_e fallback_state,
  output fsem_state_e err_state,
  output fsem_code_t err_main,
  output fsem_code_t err_sub,
  output logic err_active,
  output logic [7:0] fault_count
);

  typedef struct packed {
    logic fault_pulse;
    fsem_state_e fallback;
    fsem_state_e detect_state;
    logic [7:0] count;
    logic stale_pend;
  } fsem_mon_s;

  fsem_mon_s mon_reg;
  fsem_mon_s mon_next;

  logic stale_pulse;
  logic hit;
  fsem_code_t hit_main;
  fsem_code_t hit_sub;
  fsem_state_e hit_fallback;
  logic stale_taken;
  logic stale_seen;

  // One condition per reported code
  logic c_fw_prog;
  logic c_desc;
  logic c_fw_hw;
  logic c_boot_req;
  logic c_mbx_boot;
  logic c_mbx_sm;
  logic c_sm_cfg;
  logic c_unknown;
  logic c_illegal;

  // True for codes that name a state of the network state machine
  function automatic logic is_defined(input logic [2:0] code);
    case (code)
      FSEM_ST_INIT,
      FSEM_ST_PREOP,
      FSEM_ST_BOOT,
      FSEM_ST_SAFEOP,
      FSEM_ST_OP: is_defined = 1'b1;
      default: is_defined = 1'b0;
    endcase
  endfunction : is_defined

  // Legal steps; bootstrap is entered and left only through init.
  // A master that keeps to the order never reaches the illegal branch. [RULE11]
  function automatic logic is_legal(input fsem_state_e cur, input logic [2:0] req);
    logic ok;
    ok = 1'b0;
    if (req == cur) begin
      ok = 1'b1;
    end else begin
      case (cur)
        FSEM_ST_INIT: begin
          ok = (req == FSEM_ST_PREOP) || (req == FSEM_ST_BOOT);
        end
        FSEM_ST_PREOP: begin
          ok = (req == FSEM_ST_INIT) || (req == FSEM_ST_SAFEOP);
        end
        FSEM_ST_BOOT: begin
          ok = (req == FSEM_ST_INIT);
        end
        FSEM_ST_SAFEOP: begin
          ok = (req == FSEM_ST_INIT) || (req == FSEM_ST_PREOP) || (req == FSEM_ST_OP);
        end
        FSEM_ST_OP: begin
          ok = (req == FSEM_ST_INIT) || (req == FSEM_ST_PREOP) || (req == FSEM_ST_SAFEOP);
        end
        default: begin
          ok = 1'b0;
        end
      endcase
    end
    is_legal = ok;
  endfunction : is_legal

  // Hold states below safe-operational, drop operational to safe-operational
  function automatic fsem_state_e hold_below_safeop(input fsem_state_e cur);
    if (cur == FSEM_ST_OP) begin
      hold_below_safeop = FSEM_ST_SAFEOP;
    end else begin
      hold_below_safeop = cur;
    end
  endfunction : hold_below_safeop

  // Pre-operational and every state above it
  function automatic logic at_or_above_preop(input fsem_state_e cur);
    case (cur)
      FSEM_ST_PREOP,
      FSEM_ST_SAFEOP,
      FSEM_ST_OP: at_or_above_preop = 1'b1;
      default: at_or_above_preop = 1'b0;
    endcase
  endfunction : at_or_above_preop

  logic in_init;
  logic in_boot;
  logic in_preop;
  logic boot_req;
  logic req_defined;
  logic req_legal;

  assign in_init = (net_state == FSEM_ST_INIT);
  assign in_boot = (net_state == FSEM_ST_BOOT);
  assign in_preop = (net_state == FSEM_ST_PREOP);
  assign boot_req = req_valid && in_init && (req_state == FSEM_ST_BOOT);
  assign req_defined = is_defined(req_state);
  assign req_legal = is_legal(net_state, req_state);

  assign c_fw_prog = fw_program_fail && in_boot; // [RULE1]
  assign c_desc = desc_mismatch && in_init; // [RULE2]
  assign c_fw_hw = fw_hw_mismatch && (in_boot || in_init); // [RULE6]
  assign c_boot_req = boot_req && !boot_supported; // [RULE5]
  assign c_mbx_boot = boot_req && !mbx_boot_ok; // [RULE7]
  assign c_mbx_sm = mbx_sm_invalid && in_preop; // [RULE8]
  assign c_sm_cfg = sm_cfg_invalid && at_or_above_preop(net_state); // [RULE9]
  assign c_unknown = req_valid && !req_defined; // [RULE4]
  assign c_illegal = req_valid && !req_legal; // [RULE3]

  // The timer fires once per stall, so a stale report that loses to a
  // higher fault waits here; a refresh withdraws it
  assign stale_seen = stale_pulse || (mon_reg.stale_pend && !tx_refresh); // [RULE10]

  fsem_stale_timer #(
    .LIMIT(STALE_CYCLES)
  ) u_stale (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .refresh(tx_refresh),
    .stale_pulse(stale_pulse)
  );

  // Fault detection; when several arrive at once the first listed is reported
  always_comb begin
    hit = 1'b1;
    hit_main = `FSEM_MAIN_SM;
    hit_sub = `FSEM_CODE_NONE;
    hit_fallback = net_state;
    stale_taken = 1'b0;
    if (c_fw_prog) begin
      hit_main = `FSEM_MAIN_DL; // [RULE1]
      hit_sub = `FSEM_SUB_FW_PROG;
      hit_fallback = FSEM_ST_BOOT; // [RULE1]
    end else if (c_desc) begin
      hit_main = `FSEM_MAIN_DL; // [RULE2]
      hit_sub = `FSEM_SUB_DESC;
      hit_fallback = FSEM_ST_INIT; // [RULE2]
    end else if (c_fw_hw) begin
      hit_sub = `FSEM_SUB_FW_HW; // [RULE6]
      hit_fallback = net_state; // [RULE6]
    end else if (c_boot_req) begin
      hit_sub = `FSEM_SUB_BOOT_REQ; // [RULE5]
      hit_fallback = FSEM_ST_INIT; // [RULE5]
    end else if (c_mbx_boot) begin
      hit_sub = `FSEM_SUB_MBX_BOOT; // [RULE7]
      hit_fallback = FSEM_ST_INIT; // [RULE7]
    end else if (c_mbx_sm) begin
      hit_sub = `FSEM_SUB_MBX_SM; // [RULE8]
      hit_fallback = FSEM_ST_INIT; // [RULE8]
    end else if (c_sm_cfg) begin
      hit_sub = `FSEM_SUB_SM_CFG; // [RULE9]
      hit_fallback = FSEM_ST_PREOP; // [RULE9]
    end else if (c_unknown) begin
      hit_sub = `FSEM_SUB_UNKNOWN; // [RULE4]
      hit_fallback = hold_below_safeop(net_state); // [RULE4]
    end else if (c_illegal) begin
      hit_sub = `FSEM_SUB_ILLEGAL; // [RULE3]
      hit_fallback = hold_below_safeop(net_state); // [RULE3]
    end else if (stale_seen) begin
      hit_sub = `FSEM_SUB_TX_STALE; // [RULE10]
      hit_fallback = hold_below_safeop(net_state); // [RULE10]
      stale_taken = 1'b1;
    end else begin
      hit = 1'b0;
      hit_main = `FSEM_CODE_NONE;
    end
  end

  // Reaction register: one-cycle order, fallback target, context, count
  always_comb begin
    mon_next = mon_reg;
    mon_next.fault_pulse = 1'b0;
    mon_next.stale_pend = stale_seen && !stale_taken; // [RULE10]
    if (hit) begin
      mon_next.fault_pulse = 1'b1;
      mon_next.fallback = hit_fallback;
      mon_next.detect_state = net_state;
      if (err_clear) begin
        mon_next.count = `FSEM_COUNT_ONE;
      end else if (mon_reg.count != `FSEM_COUNT_MAX) begin
        mon_next.count = mon_reg.count + `FSEM_COUNT_ONE;
      end
    end else if (err_clear) begin
      mon_next.count = `FSEM_COUNT_ZERO;
      mon_next.detect_state = FSEM_ST_INIT;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mon_reg <= '0;
    end else if (ce) begin
      mon_reg <= mon_next;
    end
  end

  fsem_err_latch u_latch (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .set(hit),
    .set_main(hit_main),
    .set_sub(hit_sub),
    .clear(err_clear),
    .code_main(err_main),
    .code_sub(err_sub),
    .active(err_active)
  );

  assign fault_pulse = mon_reg.fault_pulse;
  assign fallback_state = mon_reg.fallback;
  assign err_state = mon_reg.detect_state;
  assign fault_count = mon_reg.count;

endmodule : fsem_monitor

/* tb/fsem_master_model.sv */
// Network master stand-in: state requests and transmit data refreshes.
// Assumes bench commands change just after a rising mclk edge.
module fsem_master_model
  import fsem_pkg::*;
(
  input wire logic mclk,
  input wire logic go,
  input wire logic [2:0] go_state,
  input wire logic refresh_en,
  output logic req_valid,
  output logic [2:0] req_state,
  output logic tx_refresh
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] tick_reg;
  initial begin
    req_valid = 1'b0;
    req_state = 3'h0;
    tx_refresh = 1'b0;
    tick_reg = 2'h0;
  end
  // One-cycle request only when told; released code lines invert
  always @(posedge mclk) begin
    req_valid <= go;
    req_state <= go ? go_state : ~req_state;
    tick_reg <= tick_reg + 2'h1;
    tx_refresh <= refresh_en && tick_reg == 2'h3;
  end
endmodule : fsem_master_model

/* tb/fsem_checker.sv */
// Port checker for fsem_monitor.
// Assumes a bind to fsem_monitor and one mclk domain.
module fsem_checker
  import fsem_pkg::*;
#(
  parameter int unsigned STALE_CYCLES = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire fsem_state_e net_state,
  input wire logic req_valid,
  input wire logic [2:0] req_state,
  input wire logic boot_supported,
  input wire logic mbx_boot_ok,
  input wire logic fw_program_fail,
  input wire logic desc_mismatch,
  input wire logic fw_hw_mismatch,
  input wire logic mbx_sm_invalid,
  input wire logic sm_cfg_invalid,
  input wire logic tx_refresh,
  input wire logic err_clear,
  input wire logic fault_pulse,
  input wire fsem_state_e fallback_state,
  input wire fsem_code_t err_main,
  input wire fsem_code_t err_sub
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [31:0] idle_reg;
  wire q = !fw_program_fail && !desc_mismatch && !fw_hw_mismatch && !mbx_sm_invalid
    && !sm_cfg_invalid;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      idle_reg <= 32'h0000_0000;
    end else if (ce) begin
      idle_reg <= tx_refresh ? 32'h0000_0000 : idle_reg + 32'h0000_0001;
    end
  end
  a_boot_fw_fail: assert property (ce && fw_program_fail && net_state == FSEM_ST_BOOT
    |=> fault_pulse && err_main == 8'h80 && err_sub == 8'h05 && fallback_state == FSEM_ST_BOOT)
    else $error("Download failure code wrong");
  a_desc_mismatch: assert property (ce && desc_mismatch && net_state == FSEM_ST_INIT
    |=> fault_pulse && err_main == 8'h80 && err_sub == 8'h06 && fallback_state == FSEM_ST_INIT)
    else $error("Description mismatch code wrong");
  a_unknown_req: assert property (ce && req_valid && req_state > 3'h4 && q
    |=> err_sub == 8'h02 && fallback_state == ($past(net_state) == FSEM_ST_OP ?
    FSEM_ST_SAFEOP : $past(net_state))) else $error("Unknown request reaction wrong");
  a_boot_refused: assert property (ce && req_valid && req_state == 3'h2 && q
    && net_state == FSEM_ST_INIT && !boot_supported ##1 fault_pulse
    |-> err_sub == 8'h03 && fallback_state == FSEM_ST_INIT) else $error("Boot refusal wrong");
  a_illegal_req: assert property (ce && req_valid && req_state == 3'h2 && q
    && net_state == FSEM_ST_OP
    |=> fault_pulse && err_main == 8'h81 && err_sub == 8'h01 && fallback_state == FSEM_ST_SAFEOP)
    else $error("Illegal request reaction wrong");
  a_mbx_boot: assert property (ce && req_valid && req_state == 3'h2 && q
    && net_state == FSEM_ST_INIT && boot_supported && !mbx_boot_ok
    |=> fault_pulse && err_sub == 8'h05 && fallback_state == FSEM_ST_INIT)
    else $error("Mailbox boot refusal wrong");
  a_fw_hw: assert property (ce && fw_hw_mismatch && !fw_program_fail && !desc_mismatch
    && net_state inside {FSEM_ST_BOOT, FSEM_ST_INIT}
    |=> err_sub == 8'h04 && fallback_state == $past(net_state)) else $error("Hardware code wrong");
  a_mbx_sm: assert property (ce && mbx_sm_invalid && net_state == FSEM_ST_PREOP
    |=> err_sub == 8'h06 && fallback_state == FSEM_ST_INIT) else $error("Mailbox setup wrong");
  a_sm_cfg: assert property (ce && sm_cfg_invalid
    && net_state inside {FSEM_ST_SAFEOP, FSEM_ST_OP}
    |=> err_sub == 8'h07 && fallback_state == FSEM_ST_PREOP) else $error("Sync setup wrong");
  a_stale_gap: assert property (fault_pulse && err_sub == 8'h08
    |-> $past(idle_reg) >= STALE_CYCLES && fallback_state != FSEM_ST_OP)
    else $error("Stale fault early");
  a_code_hold: assert property (!fault_pulse && !$past(err_clear)
    |-> $stable(err_main) && $stable(err_sub)) else $error("Latched code moved");
  c_stale: cover property (fault_pulse && err_sub == 8'h08);
  c_clear: cover property (err_clear ##1 err_main == 8'h00);
  c_drop: cover property (fault_pulse && fallback_state == FSEM_ST_SAFEOP);
endmodule : fsem_checker

/* tb/test_fieldbus_state_error_monitor.sv */
// Bench for fsem_monitor driven through a master stand-in.
// Assumes a shortened stale timeout and one 40 MHz clock.
module test_fieldbus_state_error_monitor
  import fsem_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned STALE_CYCLES = 8;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic refresh_en = 1'b1;
  logic err_clear = 1'b0;
  logic ce = 1'b1;
  logic [2:0] go_state = 3'h0;
  logic [6:0] flg = 7'h03;
  fsem_state_e net_state = FSEM_ST_INIT;
  logic req_valid, tx_refresh, fault_pulse, err_active;
  logic [2:0] req_state;
  fsem_state_e fallback_state, err_state;
  fsem_code_t err_main, err_sub;
  logic [7:0] fault_count;
  int fails = 0;
  int check_count = 0;
  always #12.5 mclk = ~mclk;
  fsem_master_model master (.mclk(mclk), .go(go), .go_state(go_state), .refresh_en(refresh_en),
    .req_valid(req_valid), .req_state(req_state), .tx_refresh(tx_refresh));
  fsem_monitor #(.STALE_CYCLES(STALE_CYCLES)) uut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .net_state(net_state), .req_valid(req_valid), .req_state(req_state),
    .boot_supported(flg[1]), .mbx_boot_ok(flg[0]), .fw_program_fail(flg[6]),
    .desc_mismatch(flg[5]), .fw_hw_mismatch(flg[4]), .mbx_sm_invalid(flg[3]),
    .sm_cfg_invalid(flg[2]), .tx_refresh(tx_refresh), .err_clear(err_clear),
    .fault_pulse(fault_pulse), .fallback_state(fallback_state), .err_state(err_state),
    .err_main(err_main), .err_sub(err_sub), .err_active(err_active), .fault_count(fault_count));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // Request in cycle 1, state and flags in cycle 2, answer seen just after cycle 2
  task automatic drive(input fsem_state_e st, input logic [6:0] f, input logic rq,
    input logic [2:0] rs);
    @(posedge mclk) #2;
    go = rq;
    go_state = rs;
    @(posedge mclk) #2;
    go = 1'b0;
    net_state = st;
    flg = f;
    @(posedge mclk) #2;
    flg = 7'h03;
  endtask : drive
  task automatic calm(input fsem_state_e st, input logic [6:0] f, input logic rq,
    input logic [2:0] rs);
    drive(st, f, rq, rs);
    chk("calm", fault_pulse, 8'h00);
  endtask : calm
  task automatic hit(input fsem_state_e st, input logic [6:0] f, input logic rq,
    input logic [2:0] rs, input fsem_code_t m, input fsem_code_t s, input fsem_state_e fb);
    drive(st, f, rq, rs);
    chk("pulse", fault_pulse, 8'h01);
    chk("main", err_main, m);
    chk("sub", err_sub, s);
    chk("fallback", fallback_state, fb);
    chk("where", err_state, st);
  endtask : hit
  task automatic t_download;
    hit(FSEM_ST_BOOT, 7'h43, 1'b0, 3'h0, 8'h80, 8'h05, FSEM_ST_BOOT);
    hit(FSEM_ST_INIT, 7'h23, 1'b0, 3'h0, 8'h80, 8'h06, FSEM_ST_INIT);
    hit(FSEM_ST_BOOT, 7'h13, 1'b0, 3'h0, 8'h81, 8'h04, FSEM_ST_BOOT);
    hit(FSEM_ST_INIT, 7'h13, 1'b0, 3'h0, 8'h81, 8'h04, FSEM_ST_INIT);
    calm(FSEM_ST_BOOT, 7'h23, 1'b0, 3'h0);
  endtask : t_download
  task automatic t_requests;
    hit(FSEM_ST_INIT, 7'h03, 1'b1, 3'h4, 8'h81, 8'h01, FSEM_ST_INIT);
    hit(FSEM_ST_OP, 7'h03, 1'b1, 3'h2, 8'h81, 8'h01, FSEM_ST_SAFEOP);
    hit(FSEM_ST_OP, 7'h03, 1'b1, 3'h7, 8'h81, 8'h02, FSEM_ST_SAFEOP);
    hit(FSEM_ST_PREOP, 7'h03, 1'b1, 3'h5, 8'h81, 8'h02, FSEM_ST_PREOP);
    hit(FSEM_ST_INIT, 7'h01, 1'b1, 3'h2, 8'h81, 8'h03, FSEM_ST_INIT);
    hit(FSEM_ST_INIT, 7'h02, 1'b1, 3'h2, 8'h81, 8'h05, FSEM_ST_INIT);
    calm(FSEM_ST_INIT, 7'h03, 1'b1, 3'h1);
    calm(FSEM_ST_OP, 7'h03, 1'b1, 3'h4);
  endtask : t_requests
  task automatic t_config;
    hit(FSEM_ST_PREOP, 7'h0B, 1'b0, 3'h0, 8'h81, 8'h06, FSEM_ST_INIT);
    hit(FSEM_ST_OP, 7'h07, 1'b0, 3'h0, 8'h81, 8'h07, FSEM_ST_PREOP);
    hit(FSEM_ST_SAFEOP, 7'h07, 1'b0, 3'h0, 8'h81, 8'h07, FSEM_ST_PREOP);
    hit(FSEM_ST_PREOP, 7'h07, 1'b0, 3'h0, 8'h81, 8'h07, FSEM_ST_PREOP);
  endtask : t_config
  // With the clock enable low a fault is not taken and codes stay put
  task automatic t_freeze;
    @(posedge mclk) #2;
    ce = 1'b0;
    drive(FSEM_ST_INIT, 7'h23, 1'b0, 3'h0);
    chk("frozen", fault_pulse, 8'h00);
    chk("kept", err_sub, 8'h07);
    ce = 1'b1;
  endtask : t_freeze
  task automatic t_stale;
    int n;
    int k;
    net_state = FSEM_ST_OP;
    // Count from a seen refresh so the gap is known exactly
    for (k = 0; k < 8 && tx_refresh !== 1'b1; k++) begin
      @(posedge mclk) #2;
    end
    refresh_en = 1'b0;
    n = 0;
    for (k = 0; k < 40 && fault_pulse !== 1'b1; k++) begin
      @(posedge mclk) #2;
      n = tx_refresh ? 0 : n + 1;
    end
    refresh_en = 1'b1;
    chk("gap", 8'(n >= STALE_CYCLES + 2 && n <= STALE_CYCLES + 4), 8'h01);
    chk("stale", err_sub, 8'h08);
    chk("drop", fallback_state, FSEM_ST_SAFEOP);
  endtask : t_stale
  task automatic t_latch;
    repeat (5) @(posedge mclk);
    #2;
    chk("held", err_sub, 8'h08);
    err_clear = 1'b1;
    @(posedge mclk) #2;
    err_clear = 1'b0;
    chk("cleared", err_main, 8'h00);
    chk("idle", err_active, 8'h00);
    hit(FSEM_ST_INIT, 7'h23, 1'b0, 3'h0, 8'h80, 8'h06, FSEM_ST_INIT);
    hit(FSEM_ST_BOOT, 7'h43, 1'b0, 3'h0, 8'h80, 8'h05, FSEM_ST_BOOT);
    chk("count", fault_count, 8'h02);
  endtask : t_latch
  initial begin
    repeat (20) @(posedge mclk);
    #2;
    rst_n = 1'b1;
    t_download;
    t_requests;
    t_config;
    t_freeze;
    t_stale;
    t_latch;
    report_and_stop;
  end
  initial begin
    #(25 * 3000);
    fails++;
    $display("Error watchdog expected end seen hang");
    report_and_stop;
  end
endmodule : test_fieldbus_state_error_monitor

bind fsem_monitor fsem_checker #(.STALE_CYCLES(STALE_CYCLES)) chk_i (.mclk(mclk),
  .rst_n(rst_n), .ce(ce), .net_state(net_state), .req_valid(req_valid),
  .req_state(req_state), .boot_supported(boot_supported), .mbx_boot_ok(mbx_boot_ok),
  .fw_program_fail(fw_program_fail),
  .desc_mismatch(desc_mismatch), .fw_hw_mismatch(fw_hw_mismatch),
  .mbx_sm_invalid(mbx_sm_invalid), .sm_cfg_invalid(sm_cfg_invalid), .tx_refresh(tx_refresh),
  .err_clear(err_clear), .fault_pulse(fault_pulse), .fallback_state(fallback_state),
  .err_main(err_main), .err_sub(err_sub));
